// file: src/mjp_port_select.sv
/*
 Multidrop scan port selector: TAP controller, device selection controller,
 local scan port machines, group/mode/GPIO scan registers and the scan path.
 Assumes all backplane and local scan pins arrive asynchronously and the
 backplane test clock is at least eight core clocks per period.
*/
`timescale 1ns/100ps
module mjp_port_select #(
	parameter int NUM_PORTS = mjp_pkg::NUM_PORTS_DEF,
	parameter int GPIO_W = mjp_pkg::GPIO_W_DEF
) (
	// Core clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// Backplane scan port
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	input wire logic i_trst_b,
	output logic o_tdo,
	output logic o_tdo_oe,
	// Slot address strap
	input wire logic [mjp_pkg::ADDR_W-1:0] i_slot,
	// Local scan ports
	output logic [NUM_PORTS-1:0] o_lsp_tck,
	output logic [NUM_PORTS-1:0] o_lsp_tms,
	output logic [NUM_PORTS-1:0] o_lsp_tdi,
	input wire logic [NUM_PORTS-1:0] i_lsp_tdo,
	output logic [NUM_PORTS-1:0] o_lsp_active,
	// General-purpose registers
	output logic [NUM_PORTS-1:0][GPIO_W-1:0] o_gpio_ded,
	output logic [NUM_PORTS-1:0][GPIO_W-1:0] o_gpio_shr
);
	import mjp_pkg::*;

	localparam int SY_TCK = 0;
	localparam int SY_TMS = 1;
	localparam int SY_TDI = 2;
	localparam int SY_TRST = 3;
	localparam int SY_TDO = 4;
	localparam int SY_SLOT = SY_TDO + NUM_PORTS;
	localparam int SYNC_W = SY_SLOT + ADDR_W;

	typedef struct packed {
		logic [SYNC_W-1:0] sync1;
		logic [SYNC_W-1:0] sync2;
		logic tck_prev;
		mjp_tap_t tap;
		mjp_sel_t sel;
		mjp_port_t [NUM_PORTS-1:0] port;
		logic [IR_W-1:0] ir_shift;
		logic [IR_W-1:0] ir_hold;
		logic bypass;
		logic [GROUP_W-1:0] group;
		logic [NUM_PORTS-1:0] mask;
		logic [NUM_PORTS-1:0][GPIO_W-1:0] gpio_ded;
		logic [NUM_PORTS-1:0][GPIO_W-1:0] gpio_shr;
		logic tdo;
		logic tdo_oe;
		logic [NUM_PORTS-1:0] lsp_tck;
		logic [NUM_PORTS-1:0] lsp_tms;
		logic [NUM_PORTS-1:0] lsp_tdi;
	} mjp_state_t;

	mjp_state_t q_ff;
	mjp_state_t nxt_q;

	function automatic mjp_tap_t mjp_tap_next(input mjp_tap_t cur, input logic tms);
		mjp_tap_t res;
		res = cur;
		unique case (cur)
			TAP_RESET: res = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: res = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: res = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: res = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: res = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: res = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: res = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: res = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: res = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: res = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: res = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: res = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: res = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: res = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: res = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: res = tms ? TAP_SEL_DR : TAP_IDLE;
		endcase
		return res;
	endfunction

	// Synchronised views and decoded selections
	logic tck_rise;
	logic tck_fall;
	logic s_tms;
	logic s_tdi;
	logic [NUM_PORTS-1:0] s_lsp_tdo;
	logic [ADDR_W-1:0] s_slot;
	logic [ADDR_W-1:0] ir_addr;
	logic [ADDR_W-1:0] group_addr;
	logic sel_any;
	logic upd_ir;
	logic is_grp;
	logic is_mode;
	logic is_ded;
	logic is_shr;
	logic [GPIO_IDX_W-1:0] gpio_idx;
	logic dr_out;
	logic chain;

	assign tck_rise = q_ff.sync2[SY_TCK] & ~q_ff.tck_prev;
	assign tck_fall = ~q_ff.sync2[SY_TCK] & q_ff.tck_prev;
	assign s_tms = q_ff.sync2[SY_TMS];
	assign s_tdi = q_ff.sync2[SY_TDI];
	assign s_lsp_tdo = q_ff.sync2[SY_TDO +: NUM_PORTS];
	assign s_slot = q_ff.sync2[SY_SLOT +: ADDR_W];
	assign ir_addr = q_ff.ir_shift[ADDR_W-1:0];
	assign group_addr = ADDR_W'(ADDR_GROUP_BASE + ADDR_W'(q_ff.group));
	assign sel_any = (q_ff.sel == SEL_SINGLE) || (q_ff.sel == SEL_MULTI);
	assign upd_ir = tck_fall && (q_ff.tap == TAP_UPD_IR);
	// Group register is only in the path while singly selected
	assign is_grp = (q_ff.ir_hold == CMD_GROUP_SEL) && (q_ff.sel == SEL_SINGLE);
	assign is_mode = (q_ff.ir_hold == CMD_MODE_SEL) && sel_any;
	assign gpio_idx = q_ff.ir_hold[GPIO_IDX_W-1:0];
	assign is_ded = sel_any && (gpio_idx < GPIO_IDX_W'(NUM_PORTS))
		&& (q_ff.ir_hold[IR_W-1:GPIO_IDX_W] == CMD_DED_GPIO_SEL[IR_W-1:GPIO_IDX_W]);
	assign is_shr = sel_any && (gpio_idx < GPIO_IDX_W'(NUM_PORTS))
		&& (q_ff.ir_hold[IR_W-1:GPIO_IDX_W] == CMD_SHR_GPIO_SEL[IR_W-1:GPIO_IDX_W]);

	// Register least significant bit leaves toward the downstream device
	always_comb begin
		dr_out = q_ff.bypass;
		if (is_grp) begin
			dr_out = q_ff.group[0];
		end else if (is_mode) begin
			dr_out = q_ff.mask[0];
		end else if (is_ded) begin
			dr_out = q_ff.gpio_ded[gpio_idx][0];
		end else if (is_shr) begin
			dr_out = q_ff.gpio_shr[gpio_idx][0];
		end
	end

	always_comb begin
		nxt_q = q_ff;
		chain = 1'b0;
		nxt_q.sync1 = {i_slot, i_lsp_tdo, i_trst_b, i_tdi, i_tms, i_tck};
		nxt_q.sync2 = q_ff.sync1;
		nxt_q.tck_prev = q_ff.sync2[SY_TCK];
		if (tck_rise) begin
			nxt_q.tap = mjp_tap_next(q_ff.tap, s_tms);
			if (q_ff.tap == TAP_CAP_IR) begin
				nxt_q.ir_shift = IR_CAPTURE;
			end
			// New bit enters the top; the bottom bit falls off
			if (q_ff.tap == TAP_SHIFT_IR) begin
				nxt_q.ir_shift = {s_tdi, q_ff.ir_shift[IR_W-1:1]};
			end
			if (q_ff.tap == TAP_CAP_DR) begin
				nxt_q.bypass = 1'b0;
			end
			// Shifting in place trades a shadow stage for outputs that ripple while scanning
			if (q_ff.tap == TAP_SHIFT_DR) begin
				if (is_grp) begin
					nxt_q.group = {s_tdi, q_ff.group[GROUP_W-1:1]};
				end else if (is_mode) begin
					nxt_q.mask = {s_tdi, q_ff.mask[NUM_PORTS-1:1]};
				end else if (is_ded) begin
					nxt_q.gpio_ded[gpio_idx] = {s_tdi, q_ff.gpio_ded[gpio_idx][GPIO_W-1:1]};
				end else if (is_shr) begin
					nxt_q.gpio_shr[gpio_idx] = {s_tdi, q_ff.gpio_shr[gpio_idx][GPIO_W-1:1]};
				end else begin
					nxt_q.bypass = s_tdi;
				end
			end
		end
		if (upd_ir) begin
			nxt_q.ir_hold = q_ff.ir_shift;
			if (q_ff.ir_shift == CMD_RETURN_WAIT) begin
				nxt_q.sel = SEL_WAIT;
			end else if (q_ff.sel == SEL_WAIT) begin
				if (ir_addr == s_slot) begin
					nxt_q.sel = SEL_SINGLE;
				end else if ((ir_addr == ADDR_BCAST) || (ir_addr == group_addr)) begin
					nxt_q.sel = SEL_MULTI;
				end else begin
					nxt_q.sel = SEL_UNSEL;
				end
			end
		end
		if (q_ff.tap == TAP_RESET) begin
			nxt_q.sel = SEL_WAIT;
		end
		if (!q_ff.sync2[SY_TRST]) begin
			nxt_q.tap = TAP_RESET;
		end
		// One machine per port, each stepping on its own state
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (sel_any && q_ff.mask[i]) begin
				unique case (q_ff.port[i])
					PORT_UNPARKED: begin
						if (q_ff.ir_hold == CMD_PARK_RESET) begin
							nxt_q.port[i] = PORT_PARKED_RESET;
						end else if (q_ff.ir_hold == CMD_PARK_IDLE && q_ff.tap == TAP_IDLE) begin
							nxt_q.port[i] = PORT_PARKED_IDLE;
						end else if (q_ff.ir_hold == CMD_PARK_PAUSE && q_ff.tap == TAP_PAUSE_DR) begin
							nxt_q.port[i] = PORT_PARKED_PDR;
						end else if (q_ff.ir_hold == CMD_PARK_PAUSE && q_ff.tap == TAP_PAUSE_IR) begin
							nxt_q.port[i] = PORT_PARKED_PIR;
						end
					end
					PORT_PARKED_RESET, PORT_PARKED_IDLE: begin
						if (q_ff.ir_hold == CMD_UNPARK && q_ff.tap == TAP_IDLE) begin
							nxt_q.port[i] = PORT_UNPARKED;
						end
					end
					PORT_PARKED_PDR: begin
						if (q_ff.ir_hold == CMD_UNPARK && q_ff.tap == TAP_PAUSE_DR) begin
							nxt_q.port[i] = PORT_UNPARKED;
						end
					end
					PORT_PARKED_PIR: begin
						if (q_ff.ir_hold == CMD_UNPARK && q_ff.tap == TAP_PAUSE_IR) begin
							nxt_q.port[i] = PORT_UNPARKED;
						end
					end
				endcase
			end
		end
		// Scan path: internal register, then unparked ports in index order
		chain = (q_ff.tap == TAP_SHIFT_IR) ? q_ff.ir_shift[0] : dr_out;
		for (int i = 0; i < NUM_PORTS; i++) begin
			nxt_q.lsp_tdi[i] = chain;
			nxt_q.lsp_tck[i] = q_ff.sync2[SY_TCK];
			nxt_q.lsp_tms[i] = (q_ff.port[i] == PORT_UNPARKED) ? s_tms
				: (q_ff.port[i] == PORT_PARKED_RESET);
			if (q_ff.port[i] == PORT_UNPARKED) begin
				chain = s_lsp_tdo[i];
			end
		end
		nxt_q.tdo = chain;
		// Only a singly selected device may drive the shared line
		nxt_q.tdo_oe = (q_ff.sel == SEL_SINGLE)
			&& ((q_ff.tap == TAP_SHIFT_IR) || (q_ff.tap == TAP_SHIFT_DR));
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q_ff <= '0;
			q_ff.tap <= TAP_RESET;
			q_ff.sel <= SEL_WAIT;
			for (int i = 0; i < NUM_PORTS; i++) begin
				q_ff.port[i] <= PORT_PARKED_RESET;
				q_ff.mask[i] <= MASK_RST_BIT;
				q_ff.lsp_tms[i] <= 1'b1;
			end
			q_ff.group <= GROUP_RST;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign o_tdo = q_ff.tdo;
	assign o_tdo_oe = q_ff.tdo_oe;
	assign o_lsp_tck = q_ff.lsp_tck;
	assign o_lsp_tms = q_ff.lsp_tms;
	assign o_lsp_tdi = q_ff.lsp_tdi;
	assign o_gpio_ded = q_ff.gpio_ded;
	assign o_gpio_shr = q_ff.gpio_shr;
	always_comb begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			o_lsp_active[i] = (q_ff.port[i] == PORT_UNPARKED);
		end
	end

	chk_multi_tdo_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(q_ff.sel == SEL_MULTI) |=> !o_tdo_oe) else $error("tdo driven while multi selected");
	chk_unsel_tdo_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(q_ff.sel == SEL_UNSEL) [*2] |-> !o_tdo_oe) else $error("tdo driven while unselected");
	chk_wait_tdo_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(q_ff.sel == SEL_WAIT) |=> !o_tdo_oe) else $error("tdo driven before selection");
	chk_ir_msb_in: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(tck_rise && q_ff.tap == TAP_SHIFT_IR) |=> (q_ff.ir_shift[IR_W-1] == $past(s_tdi)))
		else $error("ir did not take tdi at top bit");
	chk_slot_select: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(upd_ir && q_ff.sel == SEL_WAIT && ir_addr == s_slot && q_ff.ir_shift != CMD_RETURN_WAIT)
		|=> (q_ff.sel == SEL_SINGLE)) else $error("slot match did not select");
	chk_bcast_select: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(upd_ir && q_ff.sel == SEL_WAIT && ir_addr == ADDR_BCAST && ir_addr != s_slot)
		|=> (q_ff.sel == SEL_MULTI)) else $error("broadcast did not select");
	chk_group_select: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(upd_ir && q_ff.sel == SEL_WAIT && ir_addr == group_addr && ir_addr != s_slot)
		|=> (q_ff.sel == SEL_MULTI)) else $error("group match did not select");
	chk_reset_to_wait: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(q_ff.tap == TAP_RESET) |=> (q_ff.sel == SEL_WAIT)) else $error("tap reset kept selection");
	chk_port_gated: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(q_ff.port[0] != $past(q_ff.port[0])) |-> ($past(sel_any) && $past(q_ff.mask[0])))
		else $error("port moved while not selected");
	chk_idle_unpark: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		($past(q_ff.port[0]) == PORT_PARKED_IDLE && q_ff.port[0] == PORT_UNPARKED)
		|-> ($past(q_ff.tap) == TAP_IDLE)) else $error("unpark outside run-test idle");
	chk_idle_tms_low: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(q_ff.port[0] == PORT_PARKED_IDLE) |=> !o_lsp_tms[0]) else $error("idle park tms not low");
	chk_reset_tms_high: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(q_ff.port[1] == PORT_PARKED_RESET) |=> o_lsp_tms[1]) else $error("reset park tms not high");

endmodule

// file: src/mjp_pkg.sv
/*
 Constants, encodings and state types of the multidrop scan port selector.
 Assumes a core clock much faster than the backplane test clock.
*/
package mjp_pkg;

	// Widths and defaults
	localparam int IR_W = 8;
	localparam int ADDR_W = 7;
	localparam int GROUP_W = 2;
	localparam int NUM_PORTS_DEF = 3;
	localparam int GPIO_W_DEF = 8;

	// Reserved Level-1 addresses
	localparam logic [ADDR_W-1:0] ADDR_BCAST = 7'h3B;
	localparam logic [ADDR_W-1:0] ADDR_GROUP_BASE = 7'h3C;

	// Level-2 opcodes; values are arbitrary and sit above the 7-bit address range
	localparam logic [IR_W-1:0] CMD_RETURN_WAIT = 8'h80;
	localparam logic [IR_W-1:0] CMD_PARK_IDLE = 8'h81;
	localparam logic [IR_W-1:0] CMD_PARK_RESET = 8'h82;
	localparam logic [IR_W-1:0] CMD_PARK_PAUSE = 8'h83;
	localparam logic [IR_W-1:0] CMD_UNPARK = 8'h84;
	localparam logic [IR_W-1:0] CMD_GROUP_SEL = 8'h85;
	localparam logic [IR_W-1:0] CMD_MODE_SEL = 8'h86;
	localparam logic [IR_W-1:0] CMD_DED_GPIO_SEL = 8'h90;
	localparam logic [IR_W-1:0] CMD_SHR_GPIO_SEL = 8'hA0;
	localparam int GPIO_IDX_W = 4;

	// Capture and reset values
	localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
	localparam logic [GROUP_W-1:0] GROUP_RST = 2'h0;
	localparam logic MASK_RST_BIT = 1'b1;

	typedef enum logic [15:0] {
		TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004,
		TAP_CAP_DR = 16'h0008, TAP_SHIFT_DR = 16'h0010, TAP_EXIT1_DR = 16'h0020,
		TAP_PAUSE_DR = 16'h0040, TAP_EXIT2_DR = 16'h0080, TAP_UPD_DR = 16'h0100,
		TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SHIFT_IR = 16'h0800,
		TAP_EXIT1_IR = 16'h1000, TAP_PAUSE_IR = 16'h2000, TAP_EXIT2_IR = 16'h4000,
		TAP_UPD_IR = 16'h8000
	} mjp_tap_t;

	typedef enum logic [3:0] {
		SEL_WAIT = 4'h1, SEL_SINGLE = 4'h2, SEL_MULTI = 4'h4, SEL_UNSEL = 4'h8
	} mjp_sel_t;

	typedef enum logic [4:0] {
		PORT_PARKED_RESET = 5'h01, PORT_PARKED_IDLE = 5'h02, PORT_PARKED_PDR = 5'h04,
		PORT_PARKED_PIR = 5'h08, PORT_UNPARKED = 5'h10
	} mjp_port_t;

endpackage

// file: tb/mjp_ctrl_model.sv
/*
 Backplane test controller model: steps TCK, TMS, TDI and TRST of the selector.
 Assumes each task is entered just after a rising core clock edge.
*/
`timescale 1ns/100ps
module mjp_ctrl_model (
	// Core clock and observed drive enable
	input wire logic i_core_clk,
	input wire logic i_tdo_oe,
	// Backplane scan pins
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi,
	output logic o_trst_b
);
	logic shifting = 1'b0;
	logic oe_seen = 1'b0;

	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
		o_trst_b = 1'b1;
	end

	// TCK stands low between frames; TDI toggles when unused so stale data never looks valid
	task automatic tick(input logic tms, input logic tdi);
		o_tms <= tms;
		o_tdi <= tdi;
		repeat (4) @(posedge i_core_clk);
		o_tck <= 1'b1;
		// Look at the drive enable mid-cycle, where it has settled
		repeat (4) begin
			@(negedge i_core_clk);
			if (shifting && i_tdo_oe === 1'b1) oe_seen = 1'b1;
			@(posedge i_core_clk);
		end
		o_tck <= 1'b0;
	endtask

	// Idle to Pause-DR and back to Idle without shifting a bit
	task automatic pause_dr();
		tick(1'b1, ~o_tdi);
		tick(1'b0, ~o_tdi);
		tick(1'b1, ~o_tdi);
		tick(1'b0, ~o_tdi);
		tick(1'b0, ~o_tdi);
		tick(1'b1, ~o_tdi);
		tick(1'b1, ~o_tdi);
		tick(1'b0, ~o_tdi);
	endtask

	task automatic trst();
		o_trst_b <= 1'b0;
		repeat (6) @(posedge i_core_clk);
		o_trst_b <= 1'b1;
		repeat (6) @(posedge i_core_clk);
		tick(1'b0, ~o_tdi);
	endtask

	task automatic scan_ir(input logic [7:0] code);
		oe_seen = 1'b0;
		tick(1'b1, ~o_tdi);
		tick(1'b1, ~o_tdi);
		tick(1'b0, ~o_tdi);
		tick(1'b0, ~o_tdi);
		shifting = 1'b1;
		for (int i = 0; i < 8; i++) tick(i == 7, code[i]);
		shifting = 1'b0;
		tick(1'b1, ~o_tdi);
		// Ending in Idle lets a pending idle park, or an unpark of a reset- or idle-parked port, take effect
		tick(1'b0, ~o_tdi);
	endtask

	task automatic scan_dr(input logic [7:0] v, input int n);
		tick(1'b1, ~o_tdi);
		tick(1'b0, ~o_tdi);
		tick(1'b0, ~o_tdi);
		for (int i = 0; i < n; i++) tick(i == n - 1, v[i]);
		tick(1'b1, ~o_tdi);
		tick(1'b0, ~o_tdi);
	endtask
endmodule

// file: tb/multidrop_jtag_port_select_tb.sv
/*
 Self-checking bench of the multidrop scan port selector with a reference model.
 Assumes mjp_ctrl_model drives the backplane pins and the slot strap is fixed.
*/
`timescale 1ns/100ps
module multidrop_jtag_port_select_tb;
	import mjp_pkg::*;
	localparam logic [6:0] SLOT = 7'h15;
	logic core_clk = 1'b0;
	logic rst_b, tck, tms, tdi, trst_b, tdo_oe;
	logic [2:0] lsp_tdo, lsp_tms, lsp_active;
	logic [2:0][7:0] gpio_ded, gpio_shr;
	logic [7:0] m_ded[3] = '{8'h00, 8'h00, 8'h00};
	logic [7:0] m_shr[3] = '{8'h00, 8'h00, 8'h00};
	int n_errors = 0;
	int checks_done = 0;
	int seed = 33166;
	int sel = 0;
	int st[3] = '{0, 0, 0};
	logic [2:0] mask = 3'h7;
	logic [1:0] grp = 2'h0;
	logic [7:0] ir_cur = 8'h00;
	logic [6:0] addr;
	logic [7:0] cmds[2] = '{CMD_PARK_RESET, CMD_UNPARK};

	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) lsp_tdo <= 3'($random(seed));

	mjp_port_select DUT (
		.i_core_clk(core_clk), .i_rst_b(rst_b), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
		.i_trst_b(trst_b), .o_tdo(), .o_tdo_oe(tdo_oe), .i_slot(SLOT), .o_lsp_tck(),
		.o_lsp_tms(lsp_tms), .o_lsp_tdi(), .i_lsp_tdo(lsp_tdo), .o_lsp_active(lsp_active),
		.o_gpio_ded(gpio_ded), .o_gpio_shr(gpio_shr)
	);
	mjp_ctrl_model u_ctrl (
		.i_core_clk(core_clk), .i_tdo_oe(tdo_oe), .o_tck(tck), .o_tms(tms), .o_tdi(tdi),
		.o_trst_b(trst_b)
	);

	task automatic conclude();
		if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_ports();
		logic [2:0] ea, et;
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		for (int p = 0; p < 3; p++) begin
			ea[p] = (st[p] == 4);
			et[p] = (st[p] == 0);
		end
		cmp({5'h0, lsp_active}, {5'h0, ea});
		cmp({5'h0, lsp_tms}, {5'h0, et});
		for (int p = 0; p < 3; p++) begin
			cmp(gpio_ded[p], m_ded[p]);
			cmp(gpio_shr[p], m_shr[p]);
		end
		@(posedge core_clk);
	endtask

	// Reference: selection first, then masked port commands while selected
	task automatic ir(input logic [7:0] code);
		logic exp_oe;
		exp_oe = (sel == 1);
		u_ctrl.scan_ir(code);
		cmp({7'h0, u_ctrl.oe_seen}, {7'h0, exp_oe});
		if (code == CMD_RETURN_WAIT) sel = 0;
		else if (sel == 0) begin
			if (code[6:0] == SLOT) sel = 1;
			else if (code[6:0] == ADDR_BCAST) sel = 2;
			else if (code[6:0] == ADDR_GROUP_BASE + 7'(grp)) sel = 2;
			else sel = 3;
		end else if (sel == 1 || sel == 2) begin
			for (int p = 0; p < 3; p++) begin
				if (mask[p] && code == CMD_PARK_IDLE && st[p] == 4) st[p] = 1;
				if (mask[p] && code == CMD_PARK_RESET && st[p] == 4) st[p] = 0;
				if (mask[p] && code == CMD_UNPARK && st[p] <= 1) st[p] = 4;
			end
		end
		ir_cur = code;
	endtask

	task automatic dr(input logic [7:0] v, input int n);
		u_ctrl.scan_dr(v, n);
		if ((sel == 1 || sel == 2) && ir_cur == CMD_MODE_SEL) mask = v[2:0];
		if (sel == 1 && ir_cur == CMD_GROUP_SEL) grp = v[1:0];
		// Eight shifts replace the whole word, lowest bit scanned first
		for (int p = 0; p < 3; p++) begin
			if ((sel == 1 || sel == 2) && ir_cur == CMD_DED_GPIO_SEL + 8'(p)) m_ded[p] = v;
			if ((sel == 1 || sel == 2) && ir_cur == CMD_SHR_GPIO_SEL + 8'(p)) m_shr[p] = v;
		end
	endtask

	// Pause-DR parks a port under the pause command and releases it under unpark
	task automatic pdr();
		u_ctrl.pause_dr();
		for (int p = 0; p < 3; p++) begin
			if ((sel == 1 || sel == 2) && mask[p]) begin
				if (ir_cur == CMD_PARK_PAUSE && st[p] == 4) st[p] = 2;
				else if (ir_cur == CMD_UNPARK && st[p] == 2) st[p] = 4;
			end
		end
	endtask

	task automatic mode(input logic [2:0] m);
		ir(CMD_MODE_SEL);
		dr({5'h0, m}, 3);
	endtask

	task automatic treset();
		u_ctrl.trst();
		sel = 0;
	endtask

	task automatic hw_reset();
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask

	initial begin
		repeat (100000) @(posedge core_clk);
		n_errors++;
		conclude();
	end

	initial begin
		rst_b = 1'b0;
		hw_reset();
		chk_ports();
		treset();
		addr = 7'($random(seed));
		// Keep the random address unique: never a reserved or the slot address
		if (addr == SLOT || (addr >= 7'h3A && addr <= 7'h3F)) addr ^= 7'h40;
		ir({1'b0, addr});
		ir(CMD_UNPARK);
		chk_ports();
		ir(CMD_RETURN_WAIT);
		ir({1'b0, SLOT});
		ir(CMD_UNPARK);
		chk_ports();
		mode(3'h1);
		ir(CMD_PARK_IDLE);
		chk_ports();
		mode(3'h4);
		ir(CMD_PARK_RESET);
		chk_ports();
		mode(3'h7);
		ir(CMD_UNPARK);
		chk_ports();
		ir(CMD_DED_GPIO_SEL + 8'h1);
		dr(8'($random(seed)), 8);
		ir(CMD_SHR_GPIO_SEL + 8'h2);
		dr(8'($random(seed)), 8);
		chk_ports();
		mode(3'h2);
		ir(CMD_PARK_PAUSE);
		pdr();
		chk_ports();
		ir(CMD_UNPARK);
		chk_ports();
		pdr();
		chk_ports();
		ir(CMD_GROUP_SEL);
		dr(8'h02, 2);
		treset();
		ir({1'b0, ADDR_GROUP_BASE + 7'h2});
		ir(CMD_PARK_RESET);
		chk_ports();
		treset();
		ir({1'b0, ADDR_GROUP_BASE + 7'h1});
		ir(CMD_UNPARK);
		chk_ports();
		treset();
		ir({1'b0, ADDR_BCAST});
		for (int i = 0; i < 6; i++) begin
			mode(3'($random(seed)));
			ir(cmds[$unsigned($random(seed)) % 2]);
			chk_ports();
		end
		hw_reset();
		st = '{0, 0, 0};
		sel = 0;
		mask = 3'h7;
		grp = 2'h0;
		m_ded = '{8'h00, 8'h00, 8'h00};
		m_shr = '{8'h00, 8'h00, 8'h00};
		chk_ports();
		treset();
		ir({1'b0, SLOT});
		ir(CMD_UNPARK);
		chk_ports();
		conclude();
	end
endmodule
